// [prtac_pkg.sv]
// Constants, state codes and timing shared by the coexistence block.
// Assumes a single 50 MHz clock; all peer pins arrive asynchronously.
package prtac_pkg;
  // Clock period
  localparam int CLK_NS = 20;
  // Length of one priority/direction sample slot after the request rises
  localparam int PRI_SLOT_NS = 1000;
  localparam int PRI_SLOT_CYC = (PRI_SLOT_NS + CLK_NS - 1) / CLK_NS;
  // Serial coexistence link bit time (1 Mbaud)
  localparam int WCI_BIT_NS = 1000;
  localparam int WCI_BIT_CYC = WCI_BIT_NS / CLK_NS;
  localparam int TMR_W = 8;
  localparam logic [TMR_W-1:0] PRI_SLOT_LD = TMR_W'(PRI_SLOT_CYC - 1);
  localparam logic [TMR_W-1:0] WCI_BIT_LD = TMR_W'(WCI_BIT_CYC - 1);
  localparam logic [TMR_W-1:0] WCI_HALF_LD = TMR_W'(WCI_BIT_CYC / 2 - 1);
  localparam logic [TMR_W-1:0] TMR_ZERO = 8'h00;
  // Serial frame: start, 8 data bits, stop
  localparam int WCI_DATA_W = 8;
  localparam logic [3:0] WCI_BIT_START = 4'h0;
  localparam logic [3:0] WCI_BIT_STOP = 4'h9;
  localparam int RX_FIFO_DEPTH = 8;
  // Synchroniser lanes
  localparam int SY_W = 5;
  localparam int SY_REQ = 0;
  localparam int SY_PRI = 1;
  localparam int SY_DIR = 2;
  localparam int SY_OVL = 3;
  localparam int SY_RX = 4;
  localparam logic [SY_W-1:0] SY_IDLE = 5'h10;
  // Direction encoding on the direction pin
  localparam logic DIR_TX = 1'b1;
  // Peer request handling states
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_PRI1 = 6'h02,
    ST_PRI2 = 6'h04,
    ST_DIR = 6'h08,
    ST_DECIDE = 6'h10,
    ST_GRANT = 6'h20
  } prtac_state_t;
endpackage

// [prtac_core.sv]
// Coexistence arbiter: internal WLAN/PAN arbitration, peer radio handshake,
// serial coexistence message link with an 8-word receive FIFO.
// Assumes peer pins are asynchronous and the user side runs on clk.
`timescale 1ns/1ps

// Small synchronous FIFO, flip-flop storage
module prtac_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
    logic ov;
    logic [WIDTH-1:0] od;
  } prtac_fifo_s_t;
  prtac_fifo_s_t s_r;
  prtac_fifo_s_t s_nxt;
  logic push;
  logic pop;

  // Head word sits in its own flop so the outputs are registered; it counts toward the depth
  assign in_ready = ((s_r.cnt + (AW+1)'(s_r.ov)) != (AW+1)'(DEPTH));
  assign out_valid = s_r.ov;
  assign out_data = s_r.od;
  assign push = in_valid && in_ready;
  assign pop = (s_r.cnt != '0) && (!s_r.ov || out_ready); // Refill the head register

  // Pointer wrap uses depth, not a power of two assumption
  always_comb begin
    s_nxt = s_r;
    if (push) begin
      s_nxt.mem[s_r.wr] = in_data;
      s_nxt.wr = (s_r.wr == AW'(DEPTH - 1)) ? '0 : s_r.wr + 1'b1;
    end
    if (pop) begin
      s_nxt.rd = (s_r.rd == AW'(DEPTH - 1)) ? '0 : s_r.rd + 1'b1;
      s_nxt.od = s_r.mem[s_r.rd];
    end
    s_nxt.ov = pop || (s_r.ov && !out_ready);
    s_nxt.cnt = s_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule

module prtac_core (
  input wire logic clk,
  input wire logic nrst,
  input wire logic peer_radio_request_in,
  input wire logic peer_radio_priority_in,
  input wire logic peer_radio_direction_in,
  input wire logic peer_radio_channel_overlap_in,
  output logic peer_radio_grant_out,
  input wire logic coex_serial_rx,
  output logic coex_serial_tx,
  input wire logic cfg_pri_two_bit,
  input wire logic cfg_dir_on_pri,
  input wire logic wlan_req,
  input wire logic [1:0] wlan_pri,
  output logic wlan_grant,
  input wire logic pan_req,
  input wire logic [1:0] pan_pri,
  output logic pan_grant,
  output logic [1:0] peer_pri,
  output logic peer_tx,
  input wire logic msg_tx_valid,
  output logic msg_tx_ready,
  input wire logic [prtac_pkg::WCI_DATA_W-1:0] msg_tx_data,
  output logic msg_rx_valid,
  input wire logic msg_rx_ready,
  output logic [prtac_pkg::WCI_DATA_W-1:0] msg_rx_data,
  output logic msg_rx_overrun
);
  import prtac_pkg::*;
  typedef struct packed {
    prtac_state_t st;
    logic [TMR_W-1:0] tmr;
    logic [1:0] peer_pri;
    logic peer_tx;
    logic peer_grant;
    logic wlan_grant;
    logic pan_grant;
    logic [2:0][SY_W-1:0] sy;
    logic [SY_W-1:0] filt;
    logic rx_busy;
    logic [3:0] rx_bit;
    logic [TMR_W-1:0] rx_tmr;
    logic [WCI_DATA_W-1:0] rx_sh;
    logic rx_push;
    logic overrun;
    logic tx_busy;
    logic tx_ready;
    logic [3:0] tx_bit;
    logic [TMR_W-1:0] tx_tmr;
    logic [WCI_DATA_W-1:0] tx_sh;
    logic tx_line;
  } prtac_core_s_t;
  prtac_core_s_t s_r;
  prtac_core_s_t s_nxt;
  logic fifo_in_ready;
  logic req_f;
  logic pri_f;
  logic ovl_f;
  logic peer_block;
  logic peer_wins;
  assign req_f = s_r.filt[SY_REQ];
  assign pri_f = s_r.filt[SY_PRI];
  assign ovl_f = s_r.filt[SY_OVL];
  // Peer owns an overlapping channel: own radios must stay off the air
  assign peer_block = s_r.peer_grant && ovl_f;
  // Peer wins when channels are apart, WLAN idle, or its priority is higher
  assign peer_wins = !ovl_f || !wlan_req || (s_r.peer_pri > wlan_pri);
  // Outputs straight from state flops
  assign peer_radio_grant_out = s_r.peer_grant;
  assign coex_serial_tx = s_r.tx_line;
  assign wlan_grant = s_r.wlan_grant;
  assign pan_grant = s_r.pan_grant;
  assign peer_pri = s_r.peer_pri;
  assign peer_tx = s_r.peer_tx;
  assign msg_tx_ready = s_r.tx_ready;
  assign msg_rx_overrun = s_r.overrun;

  // Received messages buffered; user side may stall
  prtac_fifo #(.WIDTH(WCI_DATA_W), .DEPTH(RX_FIFO_DEPTH)) u_rx_fifo (
    .clk(clk),
    .nrst(nrst),
    .in_valid(s_r.rx_push),
    .in_ready(fifo_in_ready),
    .in_data(s_r.rx_sh),
    .out_valid(msg_rx_valid),
    .out_ready(msg_rx_ready),
    .out_data(msg_rx_data)
  );

  // Next state of the whole block
  always_comb begin
    s_nxt = s_r;
    // Three-stage sync; a change counts once stages two and three agree
    s_nxt.sy[0] = {coex_serial_rx, peer_radio_channel_overlap_in, peer_radio_direction_in,
                   peer_radio_priority_in, peer_radio_request_in};
    s_nxt.sy[1] = s_r.sy[0];
    s_nxt.sy[2] = s_r.sy[1];
    s_nxt.filt = (s_r.sy[1] & s_r.sy[2]) | (s_r.filt & (s_r.sy[1] | s_r.sy[2]));
    s_nxt.tmr = (s_r.tmr == TMR_ZERO) ? PRI_SLOT_LD : s_r.tmr - 1'b1;
    // Peer request handshake; a dropped request always withdraws the grant
    case (s_r.st)
      ST_IDLE: begin
        s_nxt.peer_grant = 1'b0;
        if (req_f) begin
          s_nxt.st = ST_PRI1;
          s_nxt.tmr = PRI_SLOT_LD;
          s_nxt.peer_pri = 2'h0;
        end
      end
      ST_PRI1: begin
        if (s_r.tmr == TMR_ZERO) begin
          // One-bit priority lands in the upper bit; the lower bit is cleared
          s_nxt.peer_pri = {pri_f, 1'b0};
          s_nxt.st = cfg_pri_two_bit ? ST_PRI2 : (cfg_dir_on_pri ? ST_DIR : ST_DECIDE);
        end
      end
      ST_PRI2: begin
        if (s_r.tmr == TMR_ZERO) begin
          s_nxt.peer_pri[0] = pri_f;
          s_nxt.st = cfg_dir_on_pri ? ST_DIR : ST_DECIDE;
        end
      end
      ST_DIR: begin
        if (s_r.tmr == TMR_ZERO) begin
          s_nxt.peer_tx = (pri_f == DIR_TX);
          s_nxt.st = ST_DECIDE;
        end
      end
      ST_DECIDE: begin
        if (!cfg_dir_on_pri) begin
          s_nxt.peer_tx = (s_r.filt[SY_DIR] == DIR_TX);
        end
        s_nxt.peer_grant = peer_wins;
        s_nxt.st = ST_GRANT;
      end
      ST_GRANT: s_nxt.st = ST_GRANT; // Decision held stable for the whole request
      default: begin
        s_nxt.st = ST_IDLE;
        s_nxt.peer_grant = 1'b0;
      end
    endcase
    if (!req_f) begin
      s_nxt.st = ST_IDLE;
      s_nxt.peer_grant = 1'b0;
    end
    // Own radios: WLAN wins ties, both yield to a peer on an overlapping channel
    s_nxt.wlan_grant = wlan_req && !peer_block && (!pan_req || (wlan_pri >= pan_pri));
    s_nxt.pan_grant = pan_req && !peer_block && !s_nxt.wlan_grant;
    // Serial receiver, sampled mid-bit
    s_nxt.rx_push = 1'b0;
    if (!s_r.rx_busy) begin
      if (!s_r.filt[SY_RX]) begin
        s_nxt.rx_busy = 1'b1;
        s_nxt.rx_bit = WCI_BIT_START;
        s_nxt.rx_tmr = WCI_HALF_LD;
      end
    end else if (s_r.rx_tmr != TMR_ZERO) begin
      s_nxt.rx_tmr = s_r.rx_tmr - 1'b1;
    end else begin
      s_nxt.rx_tmr = WCI_BIT_LD;
      s_nxt.rx_bit = s_r.rx_bit + 1'b1;
      if (s_r.rx_bit == WCI_BIT_START) begin
        // Glitch shorter than half a bit is not a start bit
        s_nxt.rx_busy = !s_r.filt[SY_RX];
      end else if (s_r.rx_bit == WCI_BIT_STOP) begin
        s_nxt.rx_busy = 1'b0;
        // Framing errors are dropped silently
        s_nxt.rx_push = s_r.filt[SY_RX];
      end else begin
        s_nxt.rx_sh = {s_r.filt[SY_RX], s_r.rx_sh[WCI_DATA_W-1:1]};
      end
    end
    // The line cannot be stalled, so a full FIFO can only lose the byte
    if (s_r.rx_push && !fifo_in_ready) begin
      s_nxt.overrun = 1'b1;
    end
    // Serial transmitter, LSB first
    if (!s_r.tx_busy) begin
      s_nxt.tx_ready = 1'b1;
      if (msg_tx_valid && s_r.tx_ready) begin
        s_nxt.tx_busy = 1'b1;
        s_nxt.tx_ready = 1'b0;
        s_nxt.tx_line = 1'b0;
        s_nxt.tx_sh = msg_tx_data;
        s_nxt.tx_bit = WCI_BIT_START;
        s_nxt.tx_tmr = WCI_BIT_LD;
      end
    end else if (s_r.tx_tmr != TMR_ZERO) begin
      s_nxt.tx_tmr = s_r.tx_tmr - 1'b1;
    end else if (s_r.tx_bit == WCI_BIT_STOP) begin
      s_nxt.tx_busy = 1'b0;
      s_nxt.tx_ready = 1'b1;
    end else begin
      s_nxt.tx_tmr = WCI_BIT_LD;
      s_nxt.tx_bit = s_r.tx_bit + 1'b1;
      // Stop bit falls out of the shift as the fill of ones
      s_nxt.tx_line = s_r.tx_sh[0];
      s_nxt.tx_sh = {1'b1, s_r.tx_sh[WCI_DATA_W-1:1]};
    end
  end

  // Idle levels: serial lines high, grants low
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_r <= '0;
      s_r.st <= ST_IDLE;
      s_r.sy <= {3{SY_IDLE}};
      s_r.filt <= SY_IDLE;
      s_r.tx_line <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  localparam int A_SLOT = PRI_SLOT_CYC;
  default clocking a_cb @(posedge clk); endclocking
  default disable iff (!nrst);

  property p_own_exclusive;
    !(s_r.wlan_grant && s_r.pan_grant);
  endproperty
  a_own_exclusive: assert property (p_own_exclusive) else $error("both own radios granted");
  property p_wlan_wins;
    wlan_req && pan_req && (wlan_pri >= pan_pri) && !peer_block |=> s_r.wlan_grant && !s_r.pan_grant;
  endproperty
  a_wlan_wins: assert property (p_wlan_wins) else $error("wlan lost a won arbitration");
  property p_grant_drop;
    !req_f |=> !s_r.peer_grant && (s_r.st == ST_IDLE);
  endproperty
  a_grant_drop: assert property (p_grant_drop) else $error("grant held without request");
  property p_no_early_grant;
    $rose(s_r.st == ST_PRI1) |-> !s_r.peer_grant [*4];
  endproperty
  a_no_early_grant: assert property (p_no_early_grant) else $error("grant before evaluation");
  // Slot ends exactly one slot after entry, unless the request was withdrawn
  property p_pri_slot;
    $rose(s_r.st == ST_PRI1) |-> ##A_SLOT ((s_r.st != ST_PRI1) && (($past(s_r.st) == ST_PRI1) || !$past(req_f)));
  endproperty
  a_pri_slot: assert property (p_pri_slot) else $error("priority slot length wrong");
  property p_pri_two;
    (s_r.st == ST_PRI2) && (s_r.tmr == TMR_ZERO) && req_f |=> s_r.peer_pri[0] == $past(pri_f);
  endproperty
  a_pri_two: assert property (p_pri_two) else $error("second priority bit not taken");
  property p_dir_serial;
    (s_r.st == ST_DIR) && (s_r.tmr == TMR_ZERO) && req_f |=> s_r.peer_tx == $past(pri_f);
  endproperty
  a_dir_serial: assert property (p_dir_serial) else $error("serial direction not taken");
  property p_dir_pin;
    (s_r.st == ST_DECIDE) && !cfg_dir_on_pri && req_f |=> s_r.peer_tx == $past(s_r.filt[SY_DIR]);
  endproperty
  a_dir_pin: assert property (p_dir_pin) else $error("direction pin misread");
  property p_overlap_block;
    peer_block |=> !s_r.wlan_grant && !s_r.pan_grant;
  endproperty
  a_overlap_block: assert property (p_overlap_block) else $error("own radio on overlapping peer");
  property p_no_overlap_grant;
    (s_r.st == ST_DECIDE) && !ovl_f && req_f |=> s_r.peer_grant;
  endproperty
  a_no_overlap_grant: assert property (p_no_overlap_grant) else $error("clear channel not granted");
  property p_tx_frame;
    msg_tx_valid && s_r.tx_ready |=>
      (!coex_serial_tx && !s_r.tx_ready) ##A_SLOT (coex_serial_tx == $past(msg_tx_data[0], A_SLOT + 1));
  endproperty
  a_tx_frame: assert property (p_tx_frame) else $error("serial frame start wrong");
endmodule

// [prtac_peer_model.sv]
// Model of the external co-located radio: request, priority, direction and
// overlap pins, plus an 8N1 coexistence serial link at 50 clocks per bit.
// Assumes clk is the block's 50 MHz clock; tasks are called by the bench.
`timescale 1ns/1ps
module prtac_peer_model (
  input wire logic clk,
  output logic req,
  output logic pri,
  output logic dir,
  output logic ovl,
  output logic ser_out,
  input wire logic ser_in
);
  import prtac_pkg::*;
  logic [7:0] got_q[$];

  // Idle pin levels
  initial begin
    req = 1'b0;
    pri = 1'b0;
    dir = 1'b0;
    ovl = 1'b0;
    ser_out = 1'b1;
  end

  // Pins change mid-slot so every sample lands well inside its slot
  task automatic ask(input logic p1, input logic p2, input logic p3, input logic d, input logic o);
    @(posedge clk);
    pri <= p1;
    dir <= d;
    ovl <= o;
    req <= 1'b1;
    repeat (PRI_SLOT_CYC + 30) @(posedge clk);
    pri <= p2;
    repeat (PRI_SLOT_CYC) @(posedge clk);
    pri <= p3;
  endtask

  // Released pins other than overlap do not keep their last value
  task automatic drop();
    @(posedge clk);
    req <= 1'b0;
    pri <= ~pri;
    dir <= ~dir;
  endtask

  // One frame, LSB first; a zero stop bit makes a framing error
  task automatic send(input logic [7:0] d, input logic stop);
    logic [9:0] f;
    f = {stop, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk);
      ser_out <= f[i];
      repeat (WCI_BIT_CYC - 1) @(posedge clk);
    end
    if (!stop) begin
      @(posedge clk);
      ser_out <= 1'b1;
      repeat (WCI_BIT_CYC) @(posedge clk);
    end
  endtask

  // Mid-bit sampling of the block's serial output; bad stop is dropped
  always begin
    logic [7:0] b;
    @(negedge ser_in);
    repeat (WCI_BIT_CYC / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (WCI_BIT_CYC) @(posedge clk);
      b[i] = ser_in;
    end
    repeat (WCI_BIT_CYC) @(posedge clk);
    if (ser_in === 1'b1) got_q.push_back(b);
  end
endmodule

// [tb_radio_coexistence_pta.sv]
// Self-checking bench for the coexistence block with a peer radio model.
// Assumes the 50 MHz clock and the peer pin timing of the block.
`timescale 1ns/1ps
module tb_radio_coexistence_pta;
  import prtac_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic req, pri, dir, ovl, srx, stx, grant, wg, pg, ptx, rxv, ovr, txr;
  logic [1:0] ppri;
  logic [7:0] rxd;
  logic two = 1'b0, dop = 1'b0, wr_i = 1'b0, pr_i = 1'b0, txv = 1'b0, rxr = 1'b0;
  logic [1:0] wp_i = 2'h0, pp_i = 2'h0;
  logic [7:0] txd = 8'h00;
  int mismatches = 0;
  int cmp_count = 0;

  prtac_core prtac_core_inst (.clk(clk), .nrst(nrst), .peer_radio_request_in(req),
    .peer_radio_priority_in(pri), .peer_radio_direction_in(dir), .peer_radio_channel_overlap_in(ovl),
    .peer_radio_grant_out(grant), .coex_serial_rx(srx), .coex_serial_tx(stx), .cfg_pri_two_bit(two),
    .cfg_dir_on_pri(dop), .wlan_req(wr_i), .wlan_pri(wp_i), .wlan_grant(wg), .pan_req(pr_i),
    .pan_pri(pp_i), .pan_grant(pg), .peer_pri(ppri), .peer_tx(ptx), .msg_tx_valid(txv),
    .msg_tx_ready(txr), .msg_tx_data(txd), .msg_rx_valid(rxv), .msg_rx_ready(rxr),
    .msg_rx_data(rxd), .msg_rx_overrun(ovr));
  prtac_peer_model prtac_peer_model_inst (.clk(clk), .req(req), .pri(pri), .dir(dir), .ovl(ovl),
    .ser_out(srx), .ser_in(stx));

  // Free-running 50 MHz clock
  always #10 clk = ~clk;

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Own radios: WLAN wins ties, both held off while the peer owns the channel
  function automatic logic [1:0] own(input logic w, input logic [1:0] wp, input logic p, input logic [1:0] pp,
                                     input logic blk);
    if (blk) return 2'h0;
    if (w && (!p || wp >= pp)) return 2'h2;
    return {1'b0, p};
  endfunction

  // Raises valid at an edge, holds valid and data until ready is seen at an edge
  task automatic send_msg(input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    txv <= 1'b1;
    txd <= d;
    do begin
      @(posedge clk);
      n++;
    end while (txr !== 1'b1 && n < 1000);
    chk(txr, 1'b1, "transmit ready");
    txv <= 1'b0;
  endtask

  initial begin
    logic [3:0] b;
    logic o, eg, ed;
    logic [1:0] ep;
    logic [7:0] d[10];
    int n;
    void'($urandom(22276));
    repeat (20) @(posedge clk);
    chk(grant, 1'b0, "grant in reset");
    chk(stx, 1'b1, "serial idle in reset");
    nrst <= 1'b1;
    repeat (5) @(posedge clk);
    // Peer handshake over all priority and direction modes
    for (int i = 0; i < 12; i++) begin
      b = 4'($urandom);
      o = 1'($urandom);
      wr_i <= 1'($urandom);
      wp_i <= 2'($urandom);
      pr_i <= 1'($urandom);
      pp_i <= 2'($urandom);
      if (i == 3) begin
        o = 1'b1;
        wr_i <= 1'b1;
        wp_i <= 2'h3;
      end
      if (i == 7) begin
        o = 1'b1;
        b[3:2] = 2'h3;
        wr_i <= 1'b1;
        wp_i <= 2'h2;
      end
      two <= i[0];
      dop <= i[1];
      ep = i[0] ? b[3:2] : {b[3], 1'b0};
      ed = i[1] ? b[1] : b[0];
      fork
        prtac_peer_model_inst.ask(b[3], i[0] ? b[2] : b[1], b[1], b[0], o);
        begin
          repeat (45) @(posedge clk);
          chk(grant, 1'b0, "grant before decision");
        end
      join
      repeat (60) @(posedge clk);
      eg = !o || !wr_i || ep > wp_i;
      chk(grant, eg, "peer grant");
      chk(ppri, ep, "peer priority");
      chk(ptx, ed, "peer direction");
      chk({wg, pg}, own(wr_i, wp_i, pr_i, pp_i, eg && o), "own grants");
      prtac_peer_model_inst.drop();
      repeat (10) @(posedge clk);
      chk(grant, 1'b0, "grant after release");
    end
    $display("peer handshake test done");
    // Own radio arbitration, first case a priority tie
    for (int i = 0; i < 16; i++) begin
      wr_i <= (i == 0) ? 1'b1 : 1'($urandom);
      pr_i <= (i == 0) ? 1'b1 : 1'($urandom);
      wp_i <= (i == 0) ? 2'h1 : 2'($urandom);
      pp_i <= (i == 0) ? 2'h1 : 2'($urandom);
      repeat (2) @(posedge clk);
      chk({wg, pg}, own(wr_i, wp_i, pr_i, pp_i, 1'b0), "own arbitration");
    end
    $display("own arbitration test done");
    // Back-to-back outgoing messages, corner bytes first
    d[0] = 8'h01;
    d[1] = 8'h80;
    d[2] = 8'($urandom);
    d[3] = 8'($urandom);
    for (int k = 0; k < 4; k++) send_msg(d[k]);
    n = 0;
    while (prtac_peer_model_inst.got_q.size() < 4 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    chk(8'(prtac_peer_model_inst.got_q.size()), 8'h04, "frames seen");
    for (int k = 0; k < 4; k++) chk(prtac_peer_model_inst.got_q[k], d[k], "sent byte");
    $display("serial transmit test done");
    // Fill receive buffer, drop a framing error, then overflow
    for (int k = 0; k < 10; k++) begin
      d[k] = 8'($urandom);
      prtac_peer_model_inst.send(d[k], k != 8);
      if (k == 8) chk(ovr, 1'b0, "no overrun on bad frame");
    end
    repeat (60) @(posedge clk);
    chk(ovr, 1'b1, "overrun on full buffer");
    rxr <= 1'b1;
    for (int j = 0; j < 8; j++) begin
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while (rxv !== 1'b1 && n < 20);
      chk(rxv, 1'b1, "receive valid");
      chk(rxd, d[j], "received byte");
    end
    @(posedge clk);
    #1;
    chk(rxv, 1'b0, "buffer empty");
    $display("serial receive test done");
    conclude();
  end

  // Watchdog well beyond the expected run of about 10000 cycles
  initial begin
    repeat (40000) @(posedge clk);
    mismatches++;
    $display("Error at %0t: watchdog expired", $time);
    conclude();
  end
endmodule
